// *** logic/smc_balance.sv ***
/*
  tank balancing engine: sweeps the reference trim capacitance, then the
  offset current, keeping the codes that gave the smallest difference.
  assumes the tanks settle within the settle time after each step.
*/
`timescale 1ns/1ns
module smc_balance
(
  input wire logic clk_in,
  input wire logic rstn_in,
  smc_cal_if.engine cal
);
  typedef enum logic [1:0]
  {
    SMC_IDLE = 2'b00,
    SMC_TRIM = 2'b01,
    SMC_OFFS = 2'b10
  } smc_bal_e;

  localparam logic [9:0] SETTLE_LAST = 10'(smc_pkg::SETTLE_CYC - 1);

  smc_bal_e state_reg;
  logic [9:0] wait_reg;
  logic [smc_pkg::SIG_W-1:0] best_reg;
  logic [smc_pkg::TRIM_W-1:0] trim_reg, best_trim_reg;
  logic [smc_pkg::OFFS_W-1:0] offs_reg, best_offs_reg;
  wire settled = (wait_reg == SETTLE_LAST);
  wire better = (cal.diff < best_reg);

  assign cal.busy = (state_reg != SMC_IDLE);
  assign cal.trim = (state_reg == SMC_TRIM) ? trim_reg : best_trim_reg;
  assign cal.offs = (state_reg == SMC_OFFS) ? offs_reg : best_offs_reg;

  // ****************************************
  // sweep, one settle period per code
  // ****************************************
  // exhaustive sweep trades time for immunity to local minima
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_reg <= SMC_IDLE;
      wait_reg <= 10'h000;
      best_reg <= '1;
      trim_reg <= '0;
      offs_reg <= '0;
      best_trim_reg <= '0;
      best_offs_reg <= '0;
    end
    else
    begin
      wait_reg <= (state_reg == SMC_IDLE || settled) ? 10'h000 : wait_reg + 10'h001;
      case (state_reg)
        SMC_IDLE:
        begin
          if (cal.start)
          begin
            state_reg <= SMC_TRIM;
            best_reg <= '1;
            trim_reg <= '0;
          end
        end
        SMC_TRIM:
        begin
          if (settled)
          begin
            if (better)
            begin
              best_reg <= cal.diff;
              best_trim_reg <= trim_reg;
            end
            trim_reg <= trim_reg + 1'b1;
            if (&trim_reg)
            begin
              state_reg <= SMC_OFFS;
              offs_reg <= '0;
            end
          end
        end
        SMC_OFFS:
        begin
          if (settled)
          begin
            if (better)
            begin
              best_reg <= cal.diff;
              best_offs_reg <= offs_reg;
            end
            offs_reg <= offs_reg + 1'b1;
            if (&offs_reg)
            begin
              state_reg <= SMC_IDLE;
            end
          end
        end
        default:
        begin
          state_reg <= SMC_IDLE;
        end
      endcase
    end
  end
endmodule // smc_balance

// *** logic/smc_cal_if.sv ***
/*
  carrier between the register core and the tank balancing engine.
  assumes both ends share clk_in and rstn_in.
*/
`timescale 1ns/1ns
interface smc_cal_if;
  logic start;
  logic busy;
  logic [smc_pkg::SIG_W-1:0] diff;
  logic [smc_pkg::TRIM_W-1:0] trim;
  logic [smc_pkg::OFFS_W-1:0] offs;

  modport core (output start, output diff, input busy, input trim, input offs);
  modport engine (input start, input diff, output busy, output trim, output offs);
endinterface

// *** logic/smc_core.sv ***
/*
  sensing mode and calibration core: byte register map, threshold
  table, linear temperature correction, trip capture and target decision.
  assumes register strobes, commands and analog samples are synchronous
  to clk_in.
*/
`timescale 1ns/1ns
module smc_core
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  output logic [7:0] reg_rdata_out,
  input wire logic balance_calibration_cmd_in,
  input wire logic trip_high_capture_cmd_in,
  input wire logic release_capture_cmd_in,
  input wire logic [9:0] tank_diff_in,
  input wire logic [9:0] tank2_loss_in,
  input wire logic [6:0] temp_index_in,
  output logic ref_tank_enable_out,
  output logic [5:0] ref_trim_cap_out,
  output logic [4:0] tank_offset_current_out,
  output logic calibration_busy_out,
  output logic target_detect_out,
  output logic switch_out
);
  // ****************************************
  // storage
  // ****************************************
  logic [7:0] miller_drive_cfg_reg;
  logic [7:0] coeff_low_reg;
  logic [7:0] mode_reg;
  logic [9:0] trip_on_reg;
  logic [9:0] trip_off_reg;
  logic detect_reg;
  logic [7:0] rdata_reg;
  logic [9:0] lut_mem [smc_pkg::LUT_N];
  smc_cal_if cal ();

  // two byte fields share one layout: low eight bits, then two more
  function automatic logic [7:0] half_of(input logic [9:0] v, input logic hi);
    half_of = hi ? {6'h00, v[9:8]} : v[7:0];
  endfunction

  // ****************************************
  // address decode
  // ****************************************
  wire in_lut = (reg_addr_in >= smc_pkg::LUT_FIRST) && (reg_addr_in <= smc_pkg::LUT_LAST);
  wire [7:0] lut_off = reg_addr_in - smc_pkg::LUT_FIRST;
  wire [6:0] lut_idx = lut_off[7:1];
  wire lut_hi = lut_off[0];
  wire wr_lut = reg_write_in && in_lut;
  wire wr_miller = reg_write_in && (reg_addr_in == smc_pkg::MILLER_DRIVE_AND_COEFF_HIGH);
  wire wr_coeff = reg_write_in && (reg_addr_in == smc_pkg::LINEAR_TEMP_COEFF_LOW);
  wire wr_mode = reg_write_in && (reg_addr_in == smc_pkg::SENSING_MODE_AND_FLAGS);

  // ****************************************
  // mode selection
  // ****************************************
  // several mode bits set together is undefined; single tank wins here
  wire single_tank_select = mode_reg[smc_pkg::SINGLE_TANK_BIT];
  wire nonferrous_select = mode_reg[smc_pkg::NONFERROUS_BIT];
  wire ferrous_select = mode_reg[smc_pkg::FERROUS_BIT];
  wire equal_sensing_select = mode_reg[smc_pkg::EQUAL_SENSING_BIT];
  // equal, nonferrous and ferrous share one differential path
  wire two_tank = !single_tank_select &&
    (equal_sensing_select || nonferrous_select || ferrous_select);
  // damped_oscillator mode: tank two loss alone, no reference tank
  wire [9:0] sense_sig = single_tank_select ? tank2_loss_in : tank_diff_in;

  // ****************************************
  // linear temperature correction
  // ****************************************
  wire [9:0] linear_temp_coeff = {miller_drive_cfg_reg[1:0], coeff_low_reg};
  wire [6:0] temp_idx = (temp_index_in > smc_pkg::IDX_MAX) ? smc_pkg::IDX_MAX : temp_index_in;
  wire signed [7:0] temp_delta = $signed({1'b0, temp_idx}) - $signed({1'b0, smc_pkg::IDX_25C});
  wire signed [18:0] corr_prod = $signed({1'b0, linear_temp_coeff}) * temp_delta;
  wire signed [12:0] corr_step = 13'(corr_prod >>> smc_pkg::COEFF_SHIFT);
  wire signed [12:0] corr_sum = $signed({3'b000, sense_sig}) - corr_step;
  // saturate so a large coefficient cannot wrap the signal
  wire [9:0] corr_sig = corr_sum[12] ? 10'h000 :
    (|corr_sum[11:10] ? 10'h3FF : corr_sum[9:0]);

  // ****************************************
  // thresholds
  // ****************************************
  wire table_on = miller_drive_cfg_reg[smc_pkg::TABLE_ENABLE_BIT];
  wire [9:0] lut_thr = lut_mem[temp_idx];
  wire [9:0] on_thr = table_on ? lut_thr : trip_on_reg;
  wire [9:0] hyst = (trip_on_reg > trip_off_reg) ? (trip_on_reg - trip_off_reg) : 10'h000;
  // the captured release gap follows the table threshold over temperature
  wire [9:0] off_thr = table_on ? ((lut_thr > hyst) ? (lut_thr - hyst) : 10'h000)
    : trip_off_reg;
  wire cmd_ok = !cal.busy;

  assign cal.start = balance_calibration_cmd_in && cmd_ok;
  assign cal.diff = tank_diff_in;

  // ****************************************
  // byte registers
  // ****************************************
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      miller_drive_cfg_reg <= smc_pkg::MILLER_RESET;
      coeff_low_reg <= smc_pkg::COEFF_LOW_RESET;
      mode_reg <= smc_pkg::MODE_RESET;
    end
    else
    begin
      if (wr_miller)
      begin
        miller_drive_cfg_reg <= reg_wdata_in;
      end
      if (wr_coeff)
      begin
        coeff_low_reg <= reg_wdata_in;
      end
      if (wr_mode)
      begin
        mode_reg <= reg_wdata_in;
      end
    end
  end

  // ****************************************
  // threshold table, two bytes per entry
  // ****************************************
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      for (int i = 0; i < smc_pkg::LUT_N; i++)
      begin
        lut_mem[i] <= 10'h000;
      end
    end
    else if (wr_lut)
    begin
      if (lut_hi)
      begin
        lut_mem[lut_idx][9:8] <= reg_wdata_in[1:0];
      end
      else
      begin
        lut_mem[lut_idx][7:0] <= reg_wdata_in;
      end
    end
  end

  // ****************************************
  // trip captures, ignored while balancing
  // ****************************************
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      trip_on_reg <= smc_pkg::TRIP_ON_RESET;
      trip_off_reg <= smc_pkg::TRIP_OFF_RESET;
    end
    else
    begin
      if (trip_high_capture_cmd_in && cmd_ok)
      begin
        trip_on_reg <= sense_sig;
      end
      if (release_capture_cmd_in && cmd_ok)
      begin
        trip_off_reg <= sense_sig;
      end
    end
  end

  // ****************************************
  // target decision with hysteresis
  // ****************************************
  // decision is frozen while balancing, since the tanks are detuned then
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      detect_reg <= 1'b0;
    end
    else if (cmd_ok)
    begin
      if (corr_sig >= on_thr)
      begin
        detect_reg <= 1'b1;
      end
      else if (corr_sig < off_thr)
      begin
        detect_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // read data, one cycle after the address
  // ****************************************
  wire [9:0] lut_rd = lut_mem[lut_idx];
  wire [7:0] rd_next =
    in_lut ? half_of(lut_rd, lut_hi) :
    (reg_addr_in == smc_pkg::MILLER_DRIVE_AND_COEFF_HIGH) ? miller_drive_cfg_reg :
    (reg_addr_in == smc_pkg::LINEAR_TEMP_COEFF_LOW) ? coeff_low_reg :
    (reg_addr_in == smc_pkg::SENSING_MODE_AND_FLAGS) ? mode_reg :
    (reg_addr_in == smc_pkg::TRIP_ON_LOW) ? half_of(trip_on_reg, 1'b0) :
    (reg_addr_in == smc_pkg::TRIP_ON_HIGH) ? half_of(trip_on_reg, 1'b1) :
    (reg_addr_in == smc_pkg::TRIP_OFF_LOW) ? half_of(trip_off_reg, 1'b0) :
    (reg_addr_in == smc_pkg::TRIP_OFF_HIGH) ? half_of(trip_off_reg, 1'b1) :
    (reg_addr_in == smc_pkg::CAL_STATUS) ? {6'h00, detect_reg, cal.busy} :
    8'h00;

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rdata_reg <= 8'h00;
    end
    else
    begin
      rdata_reg <= rd_next;
    end
  end

  // ****************************************
  // balancing engine and outputs
  // ****************************************
  smc_balance u_balance
  (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .cal(cal.engine)
  );

  assign reg_rdata_out = rdata_reg;
  assign ref_tank_enable_out = two_tank;
  assign ref_trim_cap_out = cal.trim;
  assign tank_offset_current_out = cal.offs;
  assign calibration_busy_out = cal.busy;
  assign target_detect_out = detect_reg;
  assign switch_out = detect_reg ^ mode_reg[smc_pkg::NORMALLY_CLOSED_BIT];
endmodule // smc_core

// *** logic/smc_pkg.sv ***
/*
  constants shared by the sensing mode and calibration block:
  byte map offsets, field positions, widths, reset values and timing.
  assumes a single 100 MHz clock and byte-wide register access.
*/
package smc_pkg;
  // ****************************************
  // widths
  // ****************************************
  localparam int SIG_W = 10;
  localparam int TRIM_W = 6;
  localparam int OFFS_W = 5;
  localparam int LUT_N = 67;
  localparam int IDX_W = 7;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] MILLER_DRIVE_AND_COEFF_HIGH = 8'h09;
  localparam logic [7:0] LINEAR_TEMP_COEFF_LOW = 8'h0A;
  localparam logic [7:0] SENSING_MODE_AND_FLAGS = 8'h11;
  localparam logic [7:0] TRIP_ON_LOW = 8'h1A;
  localparam logic [7:0] TRIP_ON_HIGH = 8'h1B;
  localparam logic [7:0] TRIP_OFF_LOW = 8'h1C;
  localparam logic [7:0] TRIP_OFF_HIGH = 8'h1D;
  localparam logic [7:0] CAL_STATUS = 8'h1E;
  localparam logic [7:0] LUT_FIRST = 8'h20;
  localparam logic [7:0] LUT_LAST = 8'hA5;

  // ****************************************
  // field positions
  // ****************************************
  localparam int SINGLE_TANK_BIT = 0;
  localparam int NONFERROUS_BIT = 1;
  localparam int FERROUS_BIT = 2;
  localparam int EQUAL_SENSING_BIT = 3;
  localparam int NORMALLY_CLOSED_BIT = 4;
  localparam int TABLE_ENABLE_BIT = 2;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] MILLER_RESET = 8'h00;
  localparam logic [7:0] COEFF_LOW_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h08;
  localparam logic [9:0] TRIP_ON_RESET = 10'h200;
  localparam logic [9:0] TRIP_OFF_RESET = 10'h180;

  // ****************************************
  // temperature index of the 25 C point, table step 2.5 C from -40 C
  // ****************************************
  localparam logic [6:0] IDX_25C = 7'h1A;
  localparam logic [6:0] IDX_MAX = 7'h42;
  localparam int COEFF_SHIFT = 9;

  // ****************************************
  // settle time of the tanks after a trim step
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int SETTLE_US = 10;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
endpackage

// *** tb/smc_core_monitor.sv ***
/* port checker for smc_core.
   assumes one clock domain; bound onto every smc_core instance. */
`timescale 1ns/1ns
module smc_core_monitor
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic balance_calibration_cmd_in,
  input wire logic trip_high_capture_cmd_in,
  input wire logic release_capture_cmd_in,
  input wire logic [9:0] tank_diff_in,
  input wire logic [9:0] tank2_loss_in,
  input wire logic ref_tank_enable_out,
  input wire logic [5:0] ref_trim_cap_out,
  input wire logic [4:0] tank_offset_current_out,
  input wire logic calibration_busy_out
);
  // ****************************************
  // shadow state and properties
  // ****************************************
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  logic [7:0] mode_q;
  logic [16:0] busy_cnt;
  logic [7:0] sense_lo;
  logic lut_lo;
  // captures read the loss signal when single tank is selected
  assign sense_lo = mode_q[0] ? tank2_loss_in[7:0] : tank_diff_in[7:0];
  assign lut_lo = reg_addr_in >= 8'h20 && reg_addr_in < 8'hA5 && !reg_addr_in[0];
  // shadow of the mode byte
  always_ff @(posedge clk_in or negedge rstn_in)
    if (!rstn_in)
      mode_q <= smc_pkg::MODE_RESET;
    else if (reg_write_in && reg_addr_in == 8'h11)
      mode_q <= reg_wdata_in;
  // busy length counter, too long for a repetition
  always_ff @(posedge clk_in or negedge rstn_in)
    if (!rstn_in)
      busy_cnt <= '0;
    else
      busy_cnt <= calibration_busy_out ? busy_cnt + 17'd1 : 17'd0;
  property readback(hit);
    (reg_write_in && hit) ##1 (!reg_write_in && $stable(reg_addr_in))
      |=> reg_rdata_out == $past(reg_wdata_in, 2);
  endproperty
  chk_mode_tanks: assert property (ref_tank_enable_out == (!mode_q[0] && |mode_q[3:1]))
    else $error("reference tank enable disagrees with mode");
  chk_unmapped_zero: assert property (reg_addr_in > 8'hA5 |=> reg_rdata_out == 8'h00)
    else $error("read past table not zero");
  chk_table_readback: assert property (readback(lut_lo))
    else $error("table low byte read back wrong");
  chk_coeff_readback: assert property (readback(reg_addr_in == 8'h0A))
    else $error("coefficient low byte read back wrong");
  chk_busy_start: assert property (
    balance_calibration_cmd_in && !calibration_busy_out |=> calibration_busy_out)
    else $error("balance did not start");
  chk_busy_length: assert property ($fell(calibration_busy_out) |-> busy_cnt == 17'd96000)
    else $error("balance length wrong");
  chk_trim_hold: assert property (
    !calibration_busy_out && !$past(calibration_busy_out)
    |-> $stable(ref_trim_cap_out) && $stable(tank_offset_current_out))
    else $error("trim codes moved while idle");
  chk_trip_on_cap: assert property (
    trip_high_capture_cmd_in && !calibration_busy_out
    ##1 reg_addr_in == 8'h1A |=> reg_rdata_out == $past(sense_lo, 2))
    else $error("trip-on capture wrong");
  chk_trip_off_cap: assert property (
    release_capture_cmd_in && !calibration_busy_out
    ##1 reg_addr_in == 8'h1C |=> reg_rdata_out == $past(sense_lo, 2))
    else $error("release capture wrong");
  cover property ($fell(calibration_busy_out));
  cover property (trip_high_capture_cmd_in && !calibration_busy_out);
  cover property (reg_write_in && lut_lo);
endmodule // smc_core_monitor

bind smc_core smc_core_monitor smc_core_monitor_i (.clk_in(clk_in), .rstn_in(rstn_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
  .reg_rdata_out(reg_rdata_out), .balance_calibration_cmd_in(balance_calibration_cmd_in),
  .trip_high_capture_cmd_in(trip_high_capture_cmd_in),
  .release_capture_cmd_in(release_capture_cmd_in), .tank_diff_in(tank_diff_in),
  .tank2_loss_in(tank2_loss_in), .ref_tank_enable_out(ref_tank_enable_out),
  .ref_trim_cap_out(ref_trim_cap_out), .tank_offset_current_out(tank_offset_current_out),
  .calibration_busy_out(calibration_busy_out));

// *** tb/smc_core_tb_top.sv ***
/* self-checking bench for smc_core with the programmer model.
   assumes the checker binds itself in from its own file. */
`timescale 1ns/1ns
module smc_core_tb_top;
  // ****************************************
  // signals, instances and tasks
  // ****************************************
  logic clk_in = 1'b0;
  logic rstn_in;
  logic [7:0] reg_addr_in;
  logic [7:0] reg_wdata_in;
  logic reg_write_in;
  logic [6:0] temp_index_in;
  logic [7:0] reg_rdata_out;
  logic balance_calibration_cmd_in;
  logic trip_high_capture_cmd_in;
  logic release_capture_cmd_in;
  logic [9:0] tank_diff_in;
  logic [9:0] tank2_loss_in;
  logic ref_tank_enable_out;
  logic [5:0] ref_trim_cap_out;
  logic [4:0] tank_offset_current_out;
  logic calibration_busy_out;
  logic target_detect_out;
  logic switch_out;
  int mismatches = 0;
  int compares = 0;
  // 100 MHz
  always #5 clk_in = ~clk_in;
  smc_core smc_core_i
  (
    .clk_in(clk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_rdata_out(reg_rdata_out),
    .balance_calibration_cmd_in(balance_calibration_cmd_in),
    .trip_high_capture_cmd_in(trip_high_capture_cmd_in),
    .release_capture_cmd_in(release_capture_cmd_in), .tank_diff_in(tank_diff_in),
    .tank2_loss_in(tank2_loss_in), .temp_index_in(temp_index_in),
    .ref_tank_enable_out(ref_tank_enable_out), .ref_trim_cap_out(ref_trim_cap_out),
    .tank_offset_current_out(tank_offset_current_out),
    .calibration_busy_out(calibration_busy_out), .target_detect_out(target_detect_out),
    .switch_out(switch_out)
  );
  smc_prog_model smc_prog_model_i (.clk_in(clk_in), .trim_in(ref_trim_cap_out),
    .offs_in(tank_offset_current_out), .bal_cmd_out(balance_calibration_cmd_in),
    .on_cmd_out(trip_high_capture_cmd_in), .off_cmd_out(release_capture_cmd_in),
    .diff_out(tank_diff_in), .loss_out(tank2_loss_in));
  task chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // write strobe stands one cycle; settled values are looked at 1 ns later
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clk_in);
    reg_write_in <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    @(posedge clk_in);
    #1 d = reg_rdata_out;
  endtask
  task rdw(input logic [7:0] a, output logic [9:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(a, lo);
    rd(a + 8'h01, hi);
    v = {hi[1:0], lo};
  endtask
  task t_regs;
    logic [7:0] b;
    logic [9:0] v;
    rd(8'h11, b);
    chk("mode reset", {2'b00, b}, 10'h008);
    rdw(8'h1C, v);
    chk("off reset", v, 10'h180);
    wr(8'h1A, 8'h77);
    rdw(8'h1A, v);
    chk("on read only", v, 10'h200);
    wr(8'h09, 8'h03);
    wr(8'h0A, 8'hA5);
    rd(8'h0A, b);
    v[7:0] = b;
    rd(8'h09, b);
    v[9:8] = b[1:0];
    chk("coefficient", v, 10'h3A5);
    wr(8'h21, 8'h03);
    wr(8'h20, 8'h5A);
    rdw(8'h20, v);
    chk("first entry", v, 10'h35A);
    wr(8'hA5, 8'h02);
    wr(8'hA4, 8'hC3);
    rdw(8'hA4, v);
    chk("last entry", v, 10'h2C3);
    rd(8'hA6, b);
    chk("past table", {2'b00, b}, 10'h000);
    $display("test regs done");
  endtask
  // before balancing the pair mismatch adds 0x30; single tank adds 0x40
  task t_modes;
    logic [7:0] b;
    logic [9:0] v;
    logic [9:0] a;
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h11, 8'h01 << k);
      chk("ref tank", {9'h000, ref_tank_enable_out}, {9'h000, k != 0});
      a = 10'h100 + 10'(k * 32);
      smc_prog_model_i.place(a);
      rd(8'h1A, b);
      smc_prog_model_i.send(1);
      rdw(8'h1A, v);
      chk("trip on", v, a + ((k == 0) ? 10'h040 : 10'h030));
      smc_prog_model_i.place(a - 10'h080);
      rd(8'h1C, b);
      smc_prog_model_i.send(2);
      rdw(8'h1C, v);
      chk("trip off", v, a - 10'h080 + ((k == 0) ? 10'h040 : 10'h030));
    end
    $display("test modes done");
  endtask
  // index 36 with coefficient 0x200 takes 10 off the sense; threshold 0x100
  task t_decide;
    logic [7:0] b;
    wr(8'h11, 8'h08);
    smc_prog_model_i.place(10'h1D0);
    smc_prog_model_i.send(1);
    smc_prog_model_i.place(10'h150);
    smc_prog_model_i.send(2);
    wr(8'h69, 8'h01);
    wr(8'h68, 8'h00);
    wr(8'h0A, 8'h00);
    wr(8'h09, 8'h06);
    @(posedge clk_in);
    temp_index_in <= 7'h24;
    for (int i = 0; i < 3; i++)
    begin
      smc_prog_model_i.place((i == 0) ? 10'h000 : 10'h0D8 + 10'(i));
      repeat (2) @(posedge clk_in);
      #1 chk("detect", {9'h000, target_detect_out}, {9'h000, i == 2});
    end
    // status byte carries detect in bit 1; normally closed flips the switch
    rd(8'h1E, b);
    chk("status", {2'b00, b}, 10'h002);
    chk("switch open", {9'h000, switch_out}, 10'h001);
    wr(8'h11, 8'h18);
    chk("switch closed", {9'h000, switch_out}, 10'h000);
    $display("test decide done");
  endtask
  task t_balance;
    logic [9:0] v;
    smc_prog_model_i.place(10'h000);
    smc_prog_model_i.send(0);
    #1 chk("busy start", {9'h000, calibration_busy_out}, 10'h001);
    smc_prog_model_i.send(1);
    smc_prog_model_i.send(0);
    for (int n = 0; n < 97000 && calibration_busy_out === 1'b1; n++)
      @(posedge clk_in);
    #1 chk("busy end", {9'h000, calibration_busy_out}, 10'h000);
    chk("trim", {4'h0, ref_trim_cap_out}, 10'h025);
    chk("offset", {5'h00, tank_offset_current_out}, 10'h00B);
    rdw(8'h1A, v);
    chk("busy capture", v, 10'h200);
    $display("test balance done");
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // main sequence
  initial
  begin
    rstn_in <= 1'b0;
    reg_addr_in <= 8'h00;
    reg_wdata_in <= 8'h00;
    reg_write_in <= 1'b0;
    temp_index_in <= smc_pkg::IDX_25C;
    repeat (20) @(posedge clk_in);
    rstn_in <= 1'b1;
    t_regs;
    t_modes;
    t_decide;
    t_balance;
    wrap_up;
  end
  // watchdog a little past the 96000-cycle balance
  initial
  begin
    repeat (99000) @(posedge clk_in);
    mismatches++;
    wrap_up;
  end
endmodule // smc_core_tb_top

// *** tb/smc_prog_model.sv ***
/* far side model: programmer sending calibration commands, and a tank
   pair whose mismatch follows the trim and offset codes.
   assumes commands go out on rising edges of clk_in. */
`timescale 1ns/1ns
module smc_prog_model
(
  input wire logic clk_in,
  input wire logic [5:0] trim_in,
  input wire logic [4:0] offs_in,
  output logic bal_cmd_out,
  output logic on_cmd_out,
  output logic off_cmd_out,
  output logic [9:0] diff_out,
  output logic [9:0] loss_out
);
  // ****************************************
  // tanks and command sequencer
  // ****************************************
  logic [9:0] target_amp;
  logic [5:0] trim_err;
  logic [4:0] offs_err;
  // mismatch is least at trim 0x25 and offset 0x0B, one minimum per sweep
  assign trim_err = (trim_in > 6'h25) ? trim_in - 6'h25 : 6'h25 - trim_in;
  assign offs_err = (offs_in > 5'h0B) ? offs_in - 5'h0B : 5'h0B - offs_in;
  assign diff_out = target_amp + {4'h0, trim_err} + {5'h00, offs_err};
  assign loss_out = target_amp + 10'h040;
  // quiet lines from time zero
  initial
  begin
    target_amp = 10'h000;
    bal_cmd_out = 1'b0;
    on_cmd_out = 1'b0;
    off_cmd_out = 1'b0;
  end
  // target moves at the next rising edge
  task automatic place(input logic [9:0] amp);
    @(posedge clk_in);
    target_amp <= amp;
  endtask
  // one-cycle pulse: 0 balance (only while target_amp is zero), 1 trip-on capture, 2 release capture
  task automatic send(input int kind);
    @(posedge clk_in);
    bal_cmd_out <= (kind == 0) && (target_amp == 10'h000);
    on_cmd_out <= (kind == 1);
    off_cmd_out <= (kind == 2);
    @(posedge clk_in);
    bal_cmd_out <= 1'b0;
    on_cmd_out <= 1'b0;
    off_cmd_out <= 1'b0;
  endtask
endmodule // smc_prog_model
